// [inc/alarm_integrator_pkg.sv]
package alarm_integrator_pkg;
  // register indices, byte address is four times the index
  localparam logic [7:0] IDX_CONFIG = 8'h2C;
  localparam logic [7:0] IDX_IRQ_EN = 8'h2D;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h2E;
  localparam logic [7:0] IDX_DETECT = 8'h2F;
  // configuration fields
  localparam int CFG_EXT_SF_BIT = 4;
  localparam int CFG_FMS_HI_BIT = 3;
  localparam int CFG_FMS_LO_BIT = 2;
  // enable register fields
  localparam int EN_FAST_BIT = 4;
  localparam int EN_SPEEDUP_BIT = 3;
  localparam int EN_REMOTE_BIT = 2;
  localparam int EN_FRAME_BIT = 1;
  localparam int EN_ONES_BIT = 0;
  // status register: flags sit three above states
  localparam int ST_FLAG_LSB = 3;
  // alarm vector order: 2 remote, 1 frame loss, 0 all ones
  localparam int AL_REMOTE = 2;
  localparam int AL_FRAME = 1;
  localparam int AL_ONES = 0;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  // format codes
  localparam logic [1:0] FMT_SF = 2'b00;
  localparam logic [1:0] FMT_DM = 2'b01;
  localparam logic [1:0] FMT_SUB = 2'b10;
  localparam logic [1:0] FMT_ALT_DM = 2'b11;
  localparam logic [1:0] FMT_ESF_FULL = 2'b00;
  localparam logic [1:0] FMT_ESF_RSVD = 2'b11;
  // detection thresholds
  localparam int REM_SF_MAX = 16;
  localparam int REM_DM_MAX = 4;
  localparam int REM_CODE_FULL = 8;
  localparam int REM_CODE_HALF = 4;
  localparam int ONES_MAX = 126;
  // timing
  localparam int CLK_KHZ = 50000;
  localparam int T_SHORT_MS = 40;
  localparam int T_LONG_MS = 60;
  localparam int FAST_FRAME_MS = 120;
  localparam int FAST_ONES_MS = 180;
  localparam int CYC_SHORT = T_SHORT_MS * CLK_KHZ;
  localparam int CYC_LONG = T_LONG_MS * CLK_KHZ;
  // clean intervals needed in fast mode; recovery may fall just after a
  // 40 ms boundary, and that partly dirty interval costs one of the three
  localparam int FAST_FRAME_N = FAST_FRAME_MS / T_SHORT_MS - 1;
  // an all-ones interval broken by recovery already counts as clean
  localparam int FAST_ONES_N = FAST_ONES_MS / T_LONG_MS;
  // AXI responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// [rtl/carrier_fail_alarm_integrator.sv]
// Design decision made here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
module carrier_fail_alarm_integrator #(
  parameter int ADDR_W = 12,
  parameter int SHORT_CYCLES = alarm_integrator_pkg::CYC_SHORT,
  parameter int LONG_CYCLES = alarm_integrator_pkg::CYC_LONG,
  parameter int SPEEDUP_DIV = 1000,
  parameter int SET_INTERVALS = 63,
  parameter int FRAME_CLR_INTERVALS = 15,
  parameter int ONES_CLR_INTERVALS = 15
) (
  input wire logic clk,
  input wire logic resetn,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // framer side, same clock
  input wire logic outOfFrame,
  input wire logic pcmValid,
  input wire logic pcmBit,
  input wire logic remoteBitValid,
  input wire logic remoteBit,
  input wire logic remoteCodeOk,
  // interrupt request
  output logic irq
);
  import alarm_integrator_pkg::*;

  if (SHORT_CYCLES < 2 || LONG_CYCLES < 2 || SPEEDUP_DIV < 1) begin : badTiming
    $error("interval lengths too short");
  end
  if (SET_INTERVALS < 1 || SET_INTERVALS > 127) begin : badSet
    $error("set interval count out of range");
  end
  if (FRAME_CLR_INTERVALS < 1 || FRAME_CLR_INTERVALS > 127
      || ONES_CLR_INTERVALS < 1 || ONES_CLR_INTERVALS > 127) begin : badClr
    $error("clear interval count out of range");
  end
  if (ADDR_W < 10) begin : badAddr
    $error("address too narrow for register indices");
  end

  // one integration step: returns {state, consecutive count}
  function automatic logic [7:0] integrate(input logic state,
      input logic [6:0] cnt, input logic seen, input int setN,
      input int clrN);
    logic [6:0] limit;
    limit = state ? 7'(clrN) : 7'(setN);
    integrate = {state, 7'h00};
    if (seen == state) begin
      // condition agrees with state, restart the run
      integrate = {state, 7'h00};
    end else if (cnt + 7'h01 >= limit) begin
      // run long enough, flip the alarm
      integrate = {~state, 7'h00};
    end else begin
      integrate = {state, cnt + 7'h01};
    end
  endfunction

  // saturating increment used by the event counters
  function automatic logic [7:0] satInc(input logic [7:0] v);
    satInc = (v == 8'hFF) ? v : v + 8'h01;
  endfunction

  // software-visible control
  logic extSf; // extended superframe selected
  logic [1:0] formatSelect; // {format_select_hi, format_select_lo}
  logic fastClearSelect; // fast deassertion of frame-loss and all-ones
  logic testSpeedup; // shortens the intervals, test use only
  logic [2:0] irqEn; // remote, frame loss, all ones
  logic [2:0] irqFlag; // latched change flags
  logic [2:0] alarmState; // remote, frame loss, all ones
  logic [2:0] seen; // last-interval detection results

  // bus handshake state
  logic awHeld; // write address captured
  logic wHeld; // write data captured
  logic [7:0] wIdx;
  logic [7:0] wByte;
  logic wByteEn;
  logic doWrite;
  logic rdTake;
  logic [7:0] rIdx;
  logic statusRead;

  // interval timing
  logic [23:0] shortLen;
  logic [23:0] longLen;
  logic [23:0] shortCnt;
  logic [23:0] longCnt;
  logic shortEnd;
  logic longEnd;

  // per-interval accumulators
  logic oofAny; // an out-of-frame seen this short interval
  logic oofAll; // out-of-frame held all of this long interval
  logic [7:0] remOnes; // nonzero remote bits this interval
  logic [7:0] remCodes; // error-free remote codes this interval
  logic [7:0] pcmOnes; // nonzero PCM bits this long interval
  logic remoteNow;
  logic onesNow;

  // integration counters
  logic [6:0] frameRun;
  logic [6:0] onesRun;
  logic [7:0] frameStep;
  logic [7:0] onesStep;
  logic [2:0] nextState;

  // ---------------- bus slave ----------------

  // ready while the slot is empty; stalls until the answer is taken
  assign s_axi_awready = ~awHeld & ~s_axi_bvalid;
  assign s_axi_wready = ~wHeld & ~s_axi_bvalid;
  assign s_axi_arready = ~s_axi_rvalid;
  assign doWrite = awHeld & wHeld & ~s_axi_bvalid;
  assign rdTake = s_axi_arvalid & s_axi_arready;
  assign rIdx = s_axi_araddr[9:2];
  assign statusRead = rdTake && rIdx == IDX_IRQ_STATUS;

  // address and data may arrive in either order
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      awHeld <= 1'b0;
      wHeld <= 1'b0;
      wIdx <= 8'h00;
      wByte <= 8'h00;
      wByteEn <= 1'b0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld <= 1'b1;
        wIdx <= s_axi_awaddr[9:2];
      end else if (doWrite) begin
        awHeld <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld <= 1'b1;
        wByte <= s_axi_wdata[7:0];
        wByteEn <= s_axi_wstrb[0];
      end else if (doWrite) begin
        wHeld <= 1'b0;
      end
    end
  end

  // write response, error for indices outside the four mapped registers; status and detection writes get OKAY
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (doWrite) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wIdx == IDX_CONFIG || wIdx == IDX_IRQ_EN
          || wIdx == IDX_IRQ_STATUS || wIdx == IDX_DETECT)
          ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // writable control bits; only byte lane 0 carries data
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      extSf <= 1'b0;
      formatSelect <= FMT_SF;
      fastClearSelect <= 1'b0;
      testSpeedup <= 1'b0;
      irqEn <= 3'b000;
    end else if (doWrite && wByteEn) begin
      if (wIdx == IDX_CONFIG) begin
        extSf <= wByte[CFG_EXT_SF_BIT];
        formatSelect <= {wByte[CFG_FMS_HI_BIT], wByte[CFG_FMS_LO_BIT]};
      end
      if (wIdx == IDX_IRQ_EN) begin
        fastClearSelect <= wByte[EN_FAST_BIT];
        // software is expected to leave this at zero
        testSpeedup <= wByte[EN_SPEEDUP_BIT];
        irqEn <= {wByte[EN_REMOTE_BIT], wByte[EN_FRAME_BIT],
            wByte[EN_ONES_BIT]};
      end
    end
  end

  // read data captured at the address handshake
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (rdTake) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= RESP_OKAY;
      case (rIdx)
        IDX_CONFIG: begin
          s_axi_rdata <= {27'h0, extSf, formatSelect, 2'b00};
        end
        IDX_IRQ_EN: begin
          s_axi_rdata <= {27'h0, fastClearSelect, testSpeedup, irqEn};
        end
        IDX_IRQ_STATUS: begin
          s_axi_rdata <= {26'h0, irqFlag, alarmState};
        end
        IDX_DETECT: begin
          // frame loss bit 2, remote bit 1, all ones bit 0
          s_axi_rdata <= {29'h0, seen[AL_FRAME], seen[AL_REMOTE],
              seen[AL_ONES]};
        end
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= RESP_SLVERR;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ---------------- interval timers ----------------

  // test speedup divides both intervals so a bench can reach decisions
  assign shortLen = testSpeedup ? 24'(SHORT_CYCLES / SPEEDUP_DIV + 1)
      : 24'(SHORT_CYCLES);
  assign longLen = testSpeedup ? 24'(LONG_CYCLES / SPEEDUP_DIV + 1)
      : 24'(LONG_CYCLES);
  assign shortEnd = shortCnt >= shortLen - 24'h1;
  assign longEnd = longCnt >= longLen - 24'h1;

  // free-running 40 ms and 60 ms interval counters
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shortCnt <= 24'h0;
      longCnt <= 24'h0;
    end else begin
      shortCnt <= shortEnd ? 24'h0 : shortCnt + 24'h1;
      longCnt <= longEnd ? 24'h0 : longCnt + 24'h1;
    end
  end

  // ---------------- accumulation ----------------

  // short-interval events: out-of-frame and remote signalling
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oofAny <= 1'b0;
      remOnes <= 8'h00;
      remCodes <= 8'h00;
    end else if (shortEnd) begin
      // the last cycle's out-of-frame still counts toward the closing interval, its remote strobes do not
      oofAny <= 1'b0;
      remOnes <= 8'h00;
      remCodes <= 8'h00;
    end else begin
      if (outOfFrame) begin
        oofAny <= 1'b1;
      end
      if (remoteBitValid && remoteBit) begin
        remOnes <= satInc(remOnes);
      end
      if (remoteCodeOk) begin
        remCodes <= satInc(remCodes);
      end
    end
  end

  // long-interval events: persistence of out-of-frame, PCM ones
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      oofAll <= 1'b1;
      pcmOnes <= 8'h00;
    end else if (longEnd) begin
      oofAll <= 1'b1;
      pcmOnes <= 8'h00;
    end else begin
      if (!outOfFrame) begin
        oofAll <= 1'b0;
      end
      if (pcmValid && pcmBit) begin
        pcmOnes <= satInc(pcmOnes);
      end
    end
  end

  // remote verdict per framing; the reserved extended code never sees it
  always_comb begin
    remoteNow = 1'b0;
    if (extSf) begin
      if (formatSelect == FMT_ESF_FULL) begin
        remoteNow = remCodes >= 8'(REM_CODE_FULL);
      end else if (formatSelect != FMT_ESF_RSVD) begin
        remoteNow = remCodes >= 8'(REM_CODE_HALF);
      end
    end else begin
      case (formatSelect)
        FMT_SF, FMT_SUB: begin
          remoteNow = remOnes <= 8'(REM_SF_MAX);
        end
        FMT_DM, FMT_ALT_DM: begin
          // alternate mode keeps the data-multiplexed remote test
          remoteNow = remOnes <= 8'(REM_DM_MAX);
        end
        default: begin
          remoteNow = 1'b0;
        end
      endcase
    end
  end

  // all ones: whole-interval out-of-frame and few nonzero bits
  assign onesNow = oofAll && outOfFrame && pcmOnes <= 8'(ONES_MAX);

  // detection register, loaded at each interval boundary
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      seen <= 3'b000;
    end else begin
      if (shortEnd) begin
        // frame loss is the same in every framing, alternate included
        seen[AL_FRAME] <= oofAny | outOfFrame;
        seen[AL_REMOTE] <= remoteNow;
      end
      if (longEnd) begin
        seen[AL_ONES] <= onesNow;
      end
    end
  end

  // ---------------- alarm integration ----------------

  // fast mode shortens only the clearing runs
  assign frameStep = integrate(alarmState[AL_FRAME], frameRun,
      oofAny | outOfFrame, SET_INTERVALS,
      fastClearSelect ? FAST_FRAME_N : FRAME_CLR_INTERVALS);
  // a long interval without all-ones, from zeros or framing, counts
  assign onesStep = integrate(alarmState[AL_ONES], onesRun,
      onesNow, SET_INTERVALS,
      fastClearSelect ? FAST_ONES_N : ONES_CLR_INTERVALS);

  // next alarm states; remote follows its last-interval verdict
  always_comb begin
    nextState = alarmState;
    if (shortEnd) begin
      nextState[AL_REMOTE] = remoteNow;
    end
    if (shortEnd) begin
      nextState[AL_FRAME] = frameStep[7];
    end
    if (longEnd) begin
      nextState[AL_ONES] = onesStep[7];
    end
  end

  // alarm state and run counters, stepped once per interval
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      alarmState <= 3'b000;
      frameRun <= 7'h00;
      onesRun <= 7'h00;
    end else begin
      alarmState <= nextState;
      // the step takes the verdict closing now; a lag would break fast limits
      if (shortEnd) begin
        frameRun <= frameStep[6:0];
      end
      if (longEnd) begin
        onesRun <= onesStep[6:0];
      end
    end
  end

  // ---------------- interrupts ----------------

  // change flags: a change in the read cycle survives the clear
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irqFlag <= 3'b000;
    end else begin
      irqFlag <= (statusRead ? 3'b000 : irqFlag)
          | (irqEn & (nextState ^ alarmState));
    end
  end

  // level request while any latched change flag stands
  assign irq = |irqFlag;

endmodule // carrier_fail_alarm_integrator

// [test/carrier_fail_alarm_integrator_sva.sv]
`timescale 1ns/1ns
module carrier_fail_alarm_integrator_sva #(
  parameter int ADDR_W = 12,
  parameter int SHORT_CYCLES = 200,
  parameter int LONG_CYCLES = 300
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic irq
);
  import alarm_integrator_pkg::*;
  int shortPh; // mirror of the free-running short timer
  int longPh; // mirror of the free-running long timer
  logic nearEnd; // a few cycles around any interval end
  // phases count from reset release, just like the block's own timers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      shortPh <= 0;
      longPh <= 0;
    end else begin
      shortPh <= (shortPh == SHORT_CYCLES - 1) ? 0 : shortPh + 1;
      longPh <= (longPh == LONG_CYCLES - 1) ? 0 : longPh + 1;
    end
  end
  // slack on both sides, since the exact end edge is a design detail
  assign nearEnd = (shortPh < 3) || (shortPh > SHORT_CYCLES - 4) || (longPh < 3)
    || (longPh > LONG_CYCLES - 4);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_write_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_status_taken;
    s_axi_arvalid && s_axi_arready && (s_axi_araddr[9:2] == IDX_IRQ_STATUS);
  endsequence
  a_write_answer:
    assert property (s_write_taken |=> ##1 s_axi_bvalid) else $error("write not answered");
  a_resp_held:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_ready_return:
    assert property (s_axi_bvalid && s_axi_bready |=> s_axi_awready && s_axi_wready)
    else $error("write readies not back");
  a_read_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read late");
  a_read_held:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_no_overlap:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("second read accepted");
  a_upper_zero:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  a_irq_on_end:
    assert property ($rose(irq) |-> nearEnd) else $error("irq rose away from interval end");
  a_read_clears:
    assert property (s_status_taken ##0 !nearEnd |=> !irq) else $error("irq kept after read");
  a_irq_flags:
    assert property (irq ##0 s_status_taken |=> s_axi_rdata[5:3] != 3'b000)
    else $error("irq without flag");
endmodule // carrier_fail_alarm_integrator_sva

// [test/framer_model.sv]
`timescale 1ns/1ns
module framer_model #(
  parameter int SHORT_CYCLES = 200,
  parameter int LONG_CYCLES = 300
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic lossOn,
  input wire logic [7:0] hits,
  input wire logic [7:0] pcmOnes,
  output logic outOfFrame,
  output logic pcmValid,
  output logic pcmBit,
  output logic remoteBitValid,
  output logic remoteBit,
  output logic remoteCodeOk
);
  int sc; // phase in the short interval
  int lc; // phase in the long interval
  int ri; // remote strobe index
  int pi; // pcm strobe index
  // phases start with reset so each interval holds an exact count of marks
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      sc <= 0;
      lc <= 0;
    end else begin
      sc <= (sc == SHORT_CYCLES - 1) ? 0 : sc + 1;
      lc <= (lc == LONG_CYCLES - 1) ? 0 : lc + 1;
    end
  end
  // marks sit mid-interval, so a phase slip of a cycle cannot move them across an end
  always_comb begin
    ri = sc / 4;
    pi = lc / 2;
    outOfFrame = lossOn;
    remoteBitValid = (sc % 4) == 2;
    remoteBit = remoteBitValid ? (ri >= 10 && ri < 10 + int'(hits)) : sc[0];
    remoteCodeOk = remoteBitValid && ri >= 10 && ri < 10 + int'(hits);
    pcmValid = lc[0];
    pcmBit = pcmValid ? (pi >= 10 && pi < 10 + int'(pcmOnes)) : sc[1];
  end
endmodule // framer_model

// [test/carrier_fail_alarm_integrator_test.sv]
`timescale 1ns/1ns
module carrier_fail_alarm_integrator_test;
  import alarm_integrator_pkg::*;
  localparam int SHORT = 200;
  localparam int LONG = 300;
  logic clk, resetn, awvalid, wvalid, bvalid, bready, arvalid, rvalid, rready, irq, lossOn;
  logic awready, wready, arready, oof, pcmValid, pcmBit, remValid, remBit, codeOk;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] hits, pcmOnes, val;
  int failures, compares;
  // format code, remote marks per interval, verdict expected
  logic [7:0] cfgT [15] = '{8'h00, 8'h00, 8'h04, 8'h04, 8'h08, 8'h08, 8'h0C, 8'h0C,
    8'h10, 8'h10, 8'h14, 8'h14, 8'h18, 8'h18, 8'h1C};
  logic [7:0] hitT [15] = '{16, 17, 4, 5, 16, 17, 4, 5, 8, 7, 4, 3, 4, 3, 40};
  logic expT [15] = '{1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 1, 0, 0};
  carrier_fail_alarm_integrator #(.SHORT_CYCLES(SHORT), .LONG_CYCLES(LONG),
    .SET_INTERVALS(2), .FRAME_CLR_INTERVALS(6), .ONES_CLR_INTERVALS(5)) u_dut (
    .clk(clk), .resetn(resetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .outOfFrame(oof), .pcmValid(pcmValid), .pcmBit(pcmBit), .remoteBitValid(remValid),
    .remoteBit(remBit), .remoteCodeOk(codeOk), .irq(irq));
  framer_model #(.SHORT_CYCLES(SHORT), .LONG_CYCLES(LONG)) u_framer (.clk(clk),
    .resetn(resetn), .lossOn(lossOn), .hits(hits), .pcmOnes(pcmOnes), .outOfFrame(oof),
    .pcmValid(pcmValid), .pcmBit(pcmBit), .remoteBitValid(remValid), .remoteBit(remBit),
    .remoteCodeOk(codeOk));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  task automatic finish_test();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic timedOut(input string what);
    failures++;
    $display("mismatch %s expected answer seen timeout", what);
    finish_test();
  endtask
  task automatic checkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic checkResp(input string what, input logic [1:0] exp, input logic [1:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic waitCycles(input int n);
    repeat (n) @(posedge clk);
  endtask
  // irq is looked at mid-cycle, away from the edge that may move it
  task automatic checkIrq(input string what, input logic exp);
    @(negedge clk);
    checkByte(what, {7'b0, exp}, {7'b0, irq});
    @(posedge clk);
  endtask
  // readiness is looked at mid-cycle, where it equals its value at the next edge
  task automatic axiWrite(input logic [7:0] idx, input logic [7:0] data);
    int n;
    logic awDone, wDone, answered;
    awDone = 1'b0;
    wDone = 1'b0;
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h000000, data};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b0;
    for (n = 0; n < 50; n++) begin
      @(negedge clk);
      if (bvalid && bready) break;
      awDone = awDone | awready;
      wDone = wDone | wready;
      answered = bvalid;
      @(posedge clk);
      if (awDone) awvalid <= 1'b0;
      if (wDone) wvalid <= 1'b0;
      if (answered) bready <= 1'b1;
    end
    if (n == 50) timedOut("write");
    resp = bresp;
    @(posedge clk);
  endtask
  task automatic axiRead(input logic [7:0] idx, output logic [7:0] data);
    int n;
    logic taken, answered;
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b0;
    for (n = 0; n < 50; n++) begin
      @(negedge clk);
      if (rvalid && rready) break;
      taken = arready;
      answered = rvalid;
      @(posedge clk);
      if (taken) arvalid <= 1'b0;
      if (answered) rready <= 1'b1;
    end
    if (n == 50) timedOut("read");
    data = rdata[7:0];
    resp = rresp;
    @(posedge clk);
  endtask
  task automatic expectReg(input string what, input logic [7:0] idx, input logic [7:0] mask,
    input logic [7:0] exp);
    axiRead(idx, val);
    checkByte(what, exp, val & mask);
  endtask
  // raise both alarms, let the framer recover, then read each at its fast limit:
  // the reads sample 600 and 900 cycles after recovery, 120 ms and 180 ms here
  task automatic lossClear(input logic fast);
    int n;
    axiWrite(IDX_IRQ_EN, {3'b000, fast, 4'b0111});
    lossOn <= 1'b1;
    for (n = 0; n < 60; n++) begin
      axiRead(IDX_IRQ_STATUS, val);
      if (val[1:0] === 2'b11) break;
      waitCycles(100);
    end
    if (n == 60) timedOut("alarm set");
    lossOn <= 1'b0;
    waitCycles(600);
    expectReg("frame alarm", IDX_IRQ_STATUS, 8'h02, {6'b0, !fast, 1'b0});
    waitCycles(297);
    expectReg("ones alarm", IDX_IRQ_STATUS, 8'h01, {7'b0, !fast});
  endtask
  initial begin
    failures = 0;
    compares = 0;
    resetn = 1'b0;
    {awvalid, wvalid, arvalid, lossOn} = 4'h0;
    bready = 1'b0; // raised once an answer is seen, so held answers occur
    rready = 1'b0;
    wstrb = 4'hF;
    awaddr = 12'h000;
    araddr = 12'h000;
    wdata = 32'h00000000;
    hits = 8'h00;
    pcmOnes = 8'h00;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    expectReg("enable reset", IDX_IRQ_EN, 8'hFF, 8'h00);
    expectReg("status reset", IDX_IRQ_STATUS, 8'hFF, 8'h00);
    axiRead(8'h30, val);
    checkResp("unmapped read", RESP_SLVERR, resp);
    checkByte("unmapped data", 8'h00, val);
    axiWrite(8'h30, 8'hFF);
    checkResp("unmapped write", RESP_SLVERR, resp);
    axiWrite(IDX_DETECT, 8'hFF);
    checkResp("detect write", RESP_OKAY, resp);
    expectReg("detect fixed", IDX_DETECT, 8'hFF, 8'h00);
    // remote verdict turns on with its enable clear: state moves, flag must not
    axiWrite(IDX_IRQ_EN, 8'h03);
    waitCycles(2 * SHORT + 10);
    expectReg("masked remote", IDX_IRQ_STATUS, 8'h24, 8'h04);
    checkIrq("irq masked", 1'b0);
    axiWrite(IDX_IRQ_EN, 8'h07);
    expectReg("enable rw", IDX_IRQ_EN, 8'hFF, 8'h07);
    for (int i = 0; i < 15; i++) begin
      axiWrite(IDX_CONFIG, cfgT[i]);
      hits <= hitT[i];
      waitCycles(2 * SHORT + 10);
      expectReg("remote seen", IDX_DETECT, 8'h02, {6'b0, expT[i], 1'b0});
    end
    checkIrq("irq raised", 1'b1);
    expectReg("remote flag", IDX_IRQ_STATUS, 8'h24, 8'h20);
    checkIrq("irq cleared", 1'b0);
    expectReg("flags cleared", IDX_IRQ_STATUS, 8'h38, 8'h00);
    axiWrite(IDX_CONFIG, 8'h00);
    hits <= 8'd17;
    pcmOnes <= 8'd126;
    lossOn <= 1'b1;
    waitCycles(6 * LONG);
    expectReg("loss seen", IDX_DETECT, 8'h05, 8'h05);
    expectReg("loss flags", IDX_IRQ_STATUS, 8'h1B, 8'h1B);
    lossClear(1'b0);
    lossClear(1'b1);
    axiWrite(IDX_IRQ_EN, 8'h07);
    pcmOnes <= 8'd127;
    lossOn <= 1'b1;
    waitCycles(3 * LONG + 10);
    expectReg("ones limit", IDX_DETECT, 8'h05, 8'h04);
    finish_test();
  end
endmodule // carrier_fail_alarm_integrator_test
bind carrier_fail_alarm_integrator carrier_fail_alarm_integrator_sva #(.ADDR_W(ADDR_W),
  .SHORT_CYCLES(SHORT_CYCLES), .LONG_CYCLES(LONG_CYCLES)) u_sva (.clk(clk),
  .resetn(resetn), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .irq(irq));
